// ---- core/dmr_cmd_if.sv ----
`timescale 1ns/10ps
interface dmr_cmd_if;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [1:0] ba;
   logic [12:0] addr;
   logic termination_control;
   modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, termination_control);
   modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, termination_control);
endinterface

// ---- core/dmr_ctrl_end.sv ----
`timescale 1ns/10ps
module dmr_ctrl_end (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [dmr_pkg::REG_AW-1:0] reg_addr,
   input wire logic [dmr_pkg::REG_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [dmr_pkg::REG_DW-1:0] reg_rdata_q,
   dmr_cmd_if.ctrl bus
);
   import dmr_pkg::*;

   function automatic logic lm_legal(input logic [1:0] ba, input logic [12:0] op);
      logic [2:0] cl;
      logic [2:0] wrc;
      logic [2:0] al;
      cl = op[MR_CL_LSB +: 3];
      wrc = op[MR_WR_LSB +: 3];
      al = op[EMR_AL_LSB +: 3];
      unique case (ba)
         BA_MR: lm_legal = (cl >= CL_MIN) & (cl <= CL_MAX) & (wrc >= WR_CODE_MIN) &
                           (wrc <= WR_CODE_MAX) & !op[MR_TEST];
         BA_EMR: lm_legal = (al <= AL_MAX) & (al <= ACT_TO_ACCESS_CK);
         BA_SECOND_EXTENDED_REGISTER: lm_legal = ((op & ~SECOND_EXTENDED_REGISTER_HOT_MASK) == 13'h0000);
         BA_THIRD_EXTENDED_REGISTER: lm_legal = (op == 13'h0000);
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [1:0] ctrl_q;
   logic [3:0] mrd_cnt_q;
   logic [7:0] dll_cnt_q;
   logic [3:0] odt_cnt_q;
   logic rtt_on_q;
   logic dll_due_q;
   logic refused_q;
   logic in_sr_q;
   logic bank_q;
   logic cke_q;
   logic odt_q;
   dmr_cmd_t cmd_q;
   logic [1:0] ba_q;
   logic [12:0] addr_q;

   ////////////////////////////////////////////////////////////////////////////
   // request decode
   wire wr_load = reg_wr & (reg_addr == REG_LOAD);
   wire wr_ctrl = reg_wr & (reg_addr == REG_CTRL);
   wire wr_acc = reg_wr & (reg_addr == REG_ACCESS);
   wire wr_stat = reg_wr & (reg_addr == REG_STATUS);
   wire [1:0] ld_ba = reg_wdata[LD_BA_LSB +: 2];
   wire [12:0] ld_op = reg_wdata[12:0];
   wire [2:0] kind = reg_wdata[ACC_KIND_LSB +: 3];
   wire can_issue = (mrd_cnt_q == 4'h0) & !in_sr_q;
   wire ld_ok = wr_load & can_issue & !bank_q & lm_legal(ld_ba, ld_op);
   wire ld_mr = ld_ok & (ld_ba == BA_MR);
   wire ld_emr = ld_ok & (ld_ba == BA_EMR);
   wire rtt_req = ld_op[EMR_RTT1] | ld_op[EMR_RTT0];
   wire rd_ready = bank_q & (dll_cnt_q == 8'h00) & !dll_due_q;
   wire kind_ok = (kind == ACC_ACT) | (kind == ACC_PRE) | ((kind == ACC_READ) & rd_ready) |
                  (((kind == ACC_WRITE) | (kind == ACC_WRAP)) & bank_q);
   wire acc_ok = wr_acc & can_issue & kind_ok;
   wire refuse = (wr_load & !ld_ok) | (wr_acc & !acc_ok);
   wire reg_cmd = wr_load | wr_acc;
   // termination must already be off on the pin before entry
   wire sr_go = ctrl_q[CTRL_SREF] & !in_sr_q & can_issue & !bank_q & !odt_q & !reg_cmd;
   wire sr_exit = !ctrl_q[CTRL_SREF] & in_sr_q & !reg_cmd;
   wire dll_rst_go = (ld_mr & ld_op[MR_DLLRST]) | sr_exit;
   wire acc_a10 = (kind == ACC_ACT) ? reg_wdata[10] : ((kind == ACC_WRAP) | (kind == ACC_PRE));
   wire [12:0] acc_addr = {reg_wdata[12:11], acc_a10, reg_wdata[9:0]};
   wire dmr_cmd_t acc_cmd = (kind == ACC_ACT) ? CMD_ACTIVATE :
                            (kind == ACC_READ) ? CMD_READ :
                            (kind == ACC_PRE) ? CMD_PRECHARGE : CMD_WRITE;
   wire dmr_cmd_t cmd_d = ld_ok ? CMD_LOAD : acc_ok ? acc_cmd : sr_go ? CMD_REFRESH : CMD_NOP;
   // full opcode goes out on every load
   wire [12:0] addr_d = ld_ok ? ld_op : acc_ok ? acc_addr : addr_q;
   wire [1:0] ba_d = ld_ok ? ld_ba : acc_ok ? reg_wdata[LD_BA_LSB +: 2] : ba_q;
   wire odt_block = ld_emr & rtt_req;
   wire odt_d = ctrl_q[CTRL_ODT] & rtt_on_q & (odt_cnt_q == 4'h0) & !odt_block &
                !ctrl_q[CTRL_SREF] & !in_sr_q;
   wire [6:0] status = {dll_due_q, bank_q, refused_q, in_sr_q, (odt_cnt_q != 4'h0),
                        (dll_cnt_q != 8'h00), (mrd_cnt_q != 4'h0)};
   wire [31:0] rd_mux = (reg_addr == REG_CTRL) ? {30'h0000_0000, ctrl_q} :
                        (reg_addr == REG_STATUS) ? {25'h000_0000, status} : 32'h0000_0000;

   assign bus.cke = cke_q;
   assign bus.cs_n = cmd_q[3];
   assign bus.ras_n = cmd_q[2];
   assign bus.cas_n = cmd_q[1];
   assign bus.we_n = cmd_q[0];
   assign bus.ba = ba_q;
   assign bus.addr = addr_q;
   assign bus.termination_control = odt_q;

   ////////////////////////////////////////////////////////////////////////////
   // counters and flags
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mrd_cnt_q <= '0;
         dll_cnt_q <= '0;
         odt_cnt_q <= '0;
      end else begin
         mrd_cnt_q <= ld_ok ? 4'(SETUP_LOAD_DELAY_CK) :
                      (mrd_cnt_q != 4'h0) ? mrd_cnt_q - 4'h1 : mrd_cnt_q;
         dll_cnt_q <= dll_rst_go ? 8'(DLL_LOCK_CK) :
                      (dll_cnt_q != 8'h00) ? dll_cnt_q - 8'h01 : dll_cnt_q;
         odt_cnt_q <= odt_block ? 4'(ODT_HOLD_CK) :
                      (odt_cnt_q != 4'h0) ? odt_cnt_q - 4'h1 : odt_cnt_q;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= '0;
         rtt_on_q <= 1'b0;
         dll_due_q <= 1'b0;
         refused_q <= 1'b0;
         in_sr_q <= 1'b0;
         bank_q <= 1'b0;
         reg_rdata_q <= '0;
      end else begin
         ctrl_q <= wr_ctrl ? reg_wdata[1:0] : ctrl_q;
         rtt_on_q <= ld_emr ? rtt_req : rtt_on_q;
         dll_due_q <= (ld_emr & !ld_op[EMR_DLL]) | (dll_due_q & !ld_mr) |
                      (dll_due_q & !ld_op[MR_DLLRST]);
         // a refusal in the clearing cycle still sets
         refused_q <= refuse | (refused_q & !(wr_stat & reg_wdata[ST_REFUSED]));
         in_sr_q <= sr_go | (in_sr_q & !sr_exit);
         bank_q <= (acc_ok & (kind == ACC_ACT)) | (bank_q & !(acc_ok & (kind == ACC_PRE)));
         reg_rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cke_q <= 1'b1;
         odt_q <= 1'b0;
         cmd_q <= CMD_NOP;
         ba_q <= '0;
         addr_q <= '0;
      end else begin
         cke_q <= sr_go ? 1'b0 : (sr_exit ? 1'b1 : cke_q);
         odt_q <= odt_d;
         cmd_q <= cmd_d;
         ba_q <= ba_d;
         addr_q <= addr_d;
      end
   end
endmodule // dmr_ctrl_end

// ---- core/dmr_mem_end.sv ----
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/10ps
// What this block does
// - setting dll reset bit pulses reset, self-clears
// - controller waits 200 clocks before read
// - auto precharge starts write recovery after data
// - controller programs recovery two to six
// - bit twelve picks fast or slow exit
// - column latency three to six whole clocks
// - read data at edge n plus latency
// - extended loads only idle, then wait delay
// - extended register holds until reprogrammed
// - controller enables dll, then resets it
// - self refresh stops dll, exit resets it
// - bit one reduces drive to sixty percent
// - strobe complement and redundant strobe enables
// - bit twelve disables all data outputs
// - bits six and two pick termination
// - termination pin works outside self refresh
// - termination pin low eight clocks after extended load with termination
// - posted extra latency zero to four
// - read total sums latencies, write one less
// - hot refresh rate bit, others zero
// - bank bits select target setup register
// - every field supplied on each load
module dmr_mem_end (
   input wire logic sys_clk,
   input wire logic nrst,
   dmr_cmd_if.mem bus,
   output logic dll_enabled_q,
   output logic dll_reset_q,
   output logic fast_exit_q,
   output logic dll_frozen_q,
   output logic [2:0] column_latency_q,
   output logic column_latency_bad_q,
   output logic [2:0] posted_extra_latency_q,
   output logic [3:0] read_delay_total_q,
   output logic [3:0] write_delay_total_q,
   output logic [2:0] write_recovery_q,
   output logic drive_reduced_q,
   output logic data_out_en_q,
   output logic strobe_complement_en_q,
   output logic redundant_strobe_en_q,
   output logic redundant_complement_en_q,
   output logic [7:0] termination_resistance_q,
   output logic termination_on_q,
   output logic hot_refresh_rate_q,
   output logic self_refresh_q,
   output logic power_down_q,
   output logic bank_open_q,
   output logic read_data_start_q,
   output logic write_data_start_q,
   output logic auto_precharge_start_q,
   output logic [12:0] third_extended_register_q
);
   import dmr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // command decode
   logic cke_prev_q;
   logic [12:0] main_setup_register_q;
   logic [12:0] extended_setup_register_q;
   logic [12:0] second_extended_register_q;
   dmr_cmd_t cmd;
   assign cmd = dmr_cmd_t'({bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n});
   wire live = cke_prev_q & bus.cke & !bus.cs_n;
   wire load_setup_command = live & (cmd == CMD_LOAD);
   wire lm_mr = load_setup_command & (bus.ba == BA_MR);
   wire lm_emr = load_setup_command & (bus.ba == BA_EMR);
   wire lm_second_extended_register = load_setup_command & (bus.ba == BA_SECOND_EXTENDED_REGISTER);
   wire lm_third_extended_register = load_setup_command & (bus.ba == BA_THIRD_EXTENDED_REGISTER);
   wire act = live & (cmd == CMD_ACTIVATE);
   wire pre = live & (cmd == CMD_PRECHARGE);
   wire rd = live & (cmd == CMD_READ);
   wire wr = live & (cmd == CMD_WRITE);
   wire wr_ap = wr & bus.addr[10];
   wire sr_entry = cke_prev_q & !bus.cke & !bus.cs_n & (cmd == CMD_REFRESH);
   wire sr_exit = self_refresh_q & bus.cke;
   wire pd_entry = cke_prev_q & !bus.cke & !sr_entry & !self_refresh_q;
   wire pd_exit = power_down_q & bus.cke;

   ////////////////////////////////////////////////////////////////////////////
   // setup registers
   // dll reset bit drops one cycle after capture
   wire [12:0] mr_d = lm_mr ? bus.addr : (main_setup_register_q & ~MR_SELFCLR);
   // no other source touches them: contents live until the next load
   wire [12:0] emr_d = lm_emr ? bus.addr : extended_setup_register_q;
   wire [12:0] second_extended_register_d = lm_second_extended_register ? bus.addr : second_extended_register_q;
   wire [12:0] third_extended_register_d = lm_third_extended_register ? bus.addr : third_extended_register_q;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         main_setup_register_q <= '0;
         extended_setup_register_q <= '0;
         second_extended_register_q <= '0;
         third_extended_register_q <= '0;
      end else begin
         main_setup_register_q <= mr_d;
         extended_setup_register_q <= emr_d;
         second_extended_register_q <= second_extended_register_d;
         third_extended_register_q <= third_extended_register_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // field decode, taken from captured values only
   wire [12:0] mr = main_setup_register_q;
   wire [12:0] extended_setup_register = extended_setup_register_q;
   wire [2:0] cl = mr[MR_CL_LSB +: 3];
   wire cl_bad = (cl < CL_MIN) | (cl > CL_MAX);
   wire [2:0] al = extended_setup_register[EMR_AL_LSB +: 3];
   wire [3:0] rl = {1'b0, al} + {1'b0, cl};
   wire [3:0] wl = rl - 4'h1;
   wire [2:0] wrec = mr[MR_WR_LSB +: 3] + WR_OFS;
   wire [4:0] bl_half = (mr[MR_BL_LSB +: 3] == BL8_CODE) ? BL8_HALF : BL4_HALF;
   // recovery counted from the last data beat of the burst
   wire [4:0] pre_tap = {1'b0, write_delay_total_q} + bl_half + {2'b00, write_recovery_q};
   wire [1:0] rtt_sel = {extended_setup_register[EMR_RTT1], extended_setup_register[EMR_RTT0]};
   wire [7:0] rtt_ohm = (rtt_sel == 2'h1) ? RTT_75 :
                        (rtt_sel == 2'h2) ? RTT_150 :
                        (rtt_sel == 2'h3) ? RTT_50 : RTT_OFF;
   wire q_off = extended_setup_register[EMR_QOFF];
   wire dqsn_off = extended_setup_register[EMR_DQSN];
   wire redundant_strobe_on = extended_setup_register[EMR_REDUNDANT_STROBE];
   // pin gated when termination is off, in self refresh and on its entry cycle
   wire term_d = bus.termination_control & (rtt_ohm != RTT_OFF) & !self_refresh_q & !sr_entry;
   wire active_pd = power_down_q & bank_open_q;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         column_latency_q <= '0;
         column_latency_bad_q <= 1'b0;
         posted_extra_latency_q <= '0;
         read_delay_total_q <= '0;
         write_delay_total_q <= '0;
         write_recovery_q <= '0;
         fast_exit_q <= 1'b1;
         drive_reduced_q <= 1'b0;
         data_out_en_q <= 1'b1;
         strobe_complement_en_q <= 1'b1;
         redundant_strobe_en_q <= 1'b0;
         redundant_complement_en_q <= 1'b0;
         termination_resistance_q <= RTT_OFF;
         hot_refresh_rate_q <= 1'b0;
      end else begin
         column_latency_q <= cl;
         column_latency_bad_q <= cl_bad;
         posted_extra_latency_q <= al;
         read_delay_total_q <= rl;
         write_delay_total_q <= wl;
         write_recovery_q <= wrec;
         fast_exit_q <= !mr[MR_PDX];
         drive_reduced_q <= extended_setup_register[EMR_DRV];
         data_out_en_q <= !q_off;
         strobe_complement_en_q <= !dqsn_off & !q_off;
         redundant_strobe_en_q <= redundant_strobe_on & !q_off;
         redundant_complement_en_q <= redundant_strobe_on & !dqsn_off & !q_off;
         termination_resistance_q <= rtt_ohm;
         hot_refresh_rate_q <= second_extended_register_q[SECOND_EXTENDED_REGISTER_HOT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power state, dll and termination
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cke_prev_q <= 1'b0;
         self_refresh_q <= 1'b0;
         power_down_q <= 1'b0;
         bank_open_q <= 1'b0;
         dll_enabled_q <= 1'b0;
         dll_reset_q <= 1'b0;
         dll_frozen_q <= 1'b0;
         termination_on_q <= 1'b0;
      end else begin
         cke_prev_q <= bus.cke;
         self_refresh_q <= sr_entry | (self_refresh_q & !sr_exit);
         power_down_q <= pd_entry | (power_down_q & !pd_exit);
         // any precharge closes the open row; one flag covers all banks
         bank_open_q <= act | (bank_open_q & !pre);
         dll_enabled_q <= !extended_setup_register[EMR_DLL] & !self_refresh_q & !sr_entry;
         dll_reset_q <= (lm_mr & bus.addr[MR_DLLRST]) | sr_exit;
         dll_frozen_q <= active_pd & mr[MR_PDX];
         termination_on_q <= term_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // latency timing
   dmr_pulse_delay u_rd_dly (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .pulse_in(rd),
      .tap({1'b0, read_delay_total_q}),
      .pulse_out_q(read_data_start_q)
   );

   dmr_pulse_delay u_wr_dly (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .pulse_in(wr),
      .tap({1'b0, write_delay_total_q}),
      .pulse_out_q(write_data_start_q)
   );

   dmr_pulse_delay u_ap_dly (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .pulse_in(wr_ap),
      .tap(pre_tap),
      .pulse_out_q(auto_precharge_start_q)
   );
endmodule // dmr_mem_end

// ---- core/dmr_pkg.sv ----
package dmr_pkg;
   localparam int ADDR_W = 13;
   localparam int BA_W = 2;
   // bank select during a load-setup command
   localparam logic [1:0] BA_MR = 2'h0;
   localparam logic [1:0] BA_EMR = 2'h1;
   localparam logic [1:0] BA_SECOND_EXTENDED_REGISTER = 2'h2;
   localparam logic [1:0] BA_THIRD_EXTENDED_REGISTER = 2'h3;
   // main setup register fields
   localparam int MR_BL_LSB = 0;
   localparam int MR_CL_LSB = 4;
   localparam int MR_TEST = 7;
   localparam int MR_DLLRST = 8;
   localparam int MR_WR_LSB = 9;
   localparam int MR_PDX = 12;
   localparam logic [12:0] MR_SELFCLR = 13'h0100;
   localparam logic [2:0] BL8_CODE = 3'h3;
   localparam logic [4:0] BL4_HALF = 5'h02;
   localparam logic [4:0] BL8_HALF = 5'h04;
   // extended setup register fields
   localparam int EMR_DLL = 0;
   localparam int EMR_DRV = 1;
   localparam int EMR_RTT0 = 2;
   localparam int EMR_AL_LSB = 3;
   localparam int EMR_RTT1 = 6;
   localparam int EMR_DQSN = 10;
   localparam int EMR_REDUNDANT_STROBE = 11;
   localparam int EMR_QOFF = 12;
   localparam int SECOND_EXTENDED_REGISTER_HOT = 7;
   localparam logic [12:0] SECOND_EXTENDED_REGISTER_HOT_MASK = 13'h0080;
   // legal field ranges
   localparam logic [2:0] CL_MIN = 3'h3;
   localparam logic [2:0] CL_MAX = 3'h6;
   localparam logic [2:0] WR_CODE_MIN = 3'h1;
   localparam logic [2:0] WR_CODE_MAX = 3'h5;
   localparam logic [2:0] WR_OFS = 3'h1;
   localparam logic [2:0] AL_MAX = 3'h4;
   // termination resistance in ohms
   localparam logic [7:0] RTT_OFF = 8'h00;
   localparam logic [7:0] RTT_75 = 8'h4B;
   localparam logic [7:0] RTT_150 = 8'h96;
   localparam logic [7:0] RTT_50 = 8'h32;
   // timing, in clocks
   localparam int DLL_LOCK_CK = 200;
   localparam int ODT_HOLD_CK = 8;
   localparam int SETUP_LOAD_DELAY_CK = 2;
   localparam logic [2:0] ACT_TO_ACCESS_CK = 3'h4;
   localparam int DLY_DEPTH = 32;
   localparam int DLY_TAP_W = 5;
   // controller register port
   localparam int REG_AW = 8;
   localparam int REG_DW = 32;
   localparam logic [7:0] REG_LOAD = 8'h00;
   localparam logic [7:0] REG_CTRL = 8'h04;
   localparam logic [7:0] REG_ACCESS = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam int LD_BA_LSB = 13;
   localparam int ACC_KIND_LSB = 16;
   localparam int CTRL_ODT = 0;
   localparam int CTRL_SREF = 1;
   localparam int ST_BUSY = 0;
   localparam int ST_DLLWAIT = 1;
   localparam int ST_ODTHOLD = 2;
   localparam int ST_SREF = 3;
   localparam int ST_REFUSED = 4;
   localparam int ST_BANK = 5;
   localparam int ST_DLLDUE = 6;
   localparam logic [2:0] ACC_ACT = 3'h0;
   localparam logic [2:0] ACC_READ = 3'h1;
   localparam logic [2:0] ACC_WRITE = 3'h2;
   localparam logic [2:0] ACC_WRAP = 3'h3;
   localparam logic [2:0] ACC_PRE = 3'h4;
   // {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      CMD_LOAD = 4'h0,
      CMD_REFRESH = 4'h1,
      CMD_PRECHARGE = 4'h2,
      CMD_ACTIVATE = 4'h3,
      CMD_WRITE = 4'h4,
      CMD_READ = 4'h5,
      CMD_NOP = 4'h7,
      CMD_DESEL = 4'hF
   } dmr_cmd_t;
endpackage

// ---- core/dmr_pulse_delay.sv ----
`timescale 1ns/10ps
module dmr_pulse_delay (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic pulse_in,
   input wire logic [dmr_pkg::DLY_TAP_W-1:0] tap,
   output logic pulse_out_q
);
   import dmr_pkg::*;
   logic [DLY_DEPTH-1:0] sr_q;
   wire [DLY_DEPTH:0] chain = {sr_q, pulse_in};
   // tap 0 would underflow; treat as 1
   wire [DLY_TAP_W-1:0] idx = (tap == 5'h00) ? 5'h00 : tap - 5'h01;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sr_q <= '0;
         pulse_out_q <= 1'b0;
      end else begin
         sr_q <= chain[DLY_DEPTH-1:0];
         pulse_out_q <= chain[idx];
      end
   end
endmodule // dmr_pulse_delay

// ---- sim/dmr_assertions.sv ----
`timescale 1ns/10ps
module dmr_assertions (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [1:0] ba,
   input wire logic [12:0] addr,
   input wire logic termination_control
);
   logic [7:0] dll_cnt_q;
   wire ld = cke && !cs_n && !ras_n && !cas_n && !we_n;
   wire rd = cke && !cs_n && ras_n && !cas_n && we_n;
   wire srf = !cs_n && !ras_n && !cas_n && we_n;
   wire busy = !cs_n && !(ras_n && cas_n && we_n);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////
   // saturates, so no read is flagged before the first dll reset
   // limitation: self refresh exit does not reload it
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         dll_cnt_q <= 8'hFF;
      else if (ld && ba == 2'h0 && addr[8])
         dll_cnt_q <= 8'h00;
      else if (dll_cnt_q != 8'hFF)
         dll_cnt_q <= dll_cnt_q + 8'h01;
   end
   ////////////////////////////////////////
   chk_load_gap: assert property (ld |=> !busy)
      else $error("command right after load");
   chk_dll_wait: assert property (rd |-> dll_cnt_q >= 8'hC7)
      else $error("read too soon after dll reset");
   chk_wr_range: assert property (ld && ba == 2'h0 |-> addr[11:9] inside {[3'h1:3'h5]})
      else $error("bad recovery code");
   chk_cl_range: assert property (ld && ba == 2'h0 |-> addr[6:4] inside {[3'h3:3'h6]})
      else $error("bad latency code");
   chk_al_range: assert property (ld && ba == 2'h1 |-> addr[5:3] <= 3'h4)
      else $error("bad extra latency");
   chk_odt_hold: assert property (ld && ba == 2'h1 && (addr[6] || addr[2]) |=> !termination_control [*8])
      else $error("termination pin high too soon");
   chk_sref_odt: assert property ($fell(cke) && srf |-> !termination_control && !$past(termination_control))
      else $error("termination on at self refresh entry");
   chk_hot_only: assert property (ld && ba == 2'h2 |-> (addr & 13'h1F7F) == 13'h0000)
      else $error("reserved bit set");
endmodule // dmr_assertions

// ---- sim/tb_ddr2_mode_register_decode.sv ----
`timescale 1ns/10ps
module tb_ddr2_mode_register_decode;
   import dmr_pkg::*;
   logic sys_clk, nrst, reg_wr, reg_rd;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata_q, d;
   logic dll_enabled_q, dll_reset_q, fast_exit_q, dll_frozen_q, column_latency_bad_q;
   logic [2:0] column_latency_q, posted_extra_latency_q, write_recovery_q;
   logic [3:0] read_delay_total_q, write_delay_total_q;
   logic drive_reduced_q, data_out_en_q, strobe_complement_en_q, redundant_strobe_en_q;
   logic redundant_complement_en_q, termination_on_q, hot_refresh_rate_q, self_refresh_q;
   logic power_down_q, bank_open_q, read_data_start_q, write_data_start_q, auto_precharge_start_q;
   logic [7:0] termination_resistance_q;
   logic [12:0] third_extended_register_q;
   int bad_count, checks, cyc, rd_at, wr_at, rd_lat, wr_lat, ap_lat, pulses;
   int cl, wrc, pdx, al, termination_resistance, ex, hot;
   int rtt_ohm[4] = '{8'h00, 8'h4B, 8'h96, 8'h32};
   dmr_cmd_if bus_if ();
   dmr_ctrl_end dmr_ctrl_end_inst (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_q, .bus(bus_if.ctrl));
   dmr_mem_end dmr_mem_end_inst (.sys_clk, .nrst, .bus(bus_if.mem), .dll_enabled_q, .dll_reset_q,
      .fast_exit_q, .dll_frozen_q, .column_latency_q, .column_latency_bad_q, .posted_extra_latency_q,
      .read_delay_total_q, .write_delay_total_q, .write_recovery_q, .drive_reduced_q, .data_out_en_q,
      .strobe_complement_en_q, .redundant_strobe_en_q, .redundant_complement_en_q,
      .termination_resistance_q, .termination_on_q, .hot_refresh_rate_q, .self_refresh_q,
      .power_down_q, .bank_open_q, .read_data_start_q, .write_data_start_q,
      .auto_precharge_start_q, .third_extended_register_q);
   dmr_assertions dmr_assertions_inst (.sys_clk, .nrst, .cke(bus_if.cke), .cs_n(bus_if.cs_n),
      .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n), .we_n(bus_if.we_n), .ba(bus_if.ba),
      .addr(bus_if.addr), .termination_control(bus_if.termination_control));
   ////////////////////////////////////////
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %0h seen %0h", n, e, g);
      end
   endtask
   // tail of three edges covers capture plus decode and the load gap
   task automatic wr(logic [7:0] a, logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'h1;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge sys_clk);
      reg_rd <= 1'h0;
      #1 d = reg_rdata_q;
   endtask
   task automatic load(logic [1:0] b, logic [12:0] op);
      wr(REG_LOAD, {17'h0_0000, b, op});
   endtask
   task automatic acc(logic [2:0] k);
      wr(REG_ACCESS, {13'h0000, k, 16'h0000});
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////
   always @(posedge sys_clk) begin
      cyc++;
      if (bus_if.cke && !bus_if.cs_n && bus_if.ras_n && !bus_if.cas_n) begin
         if (bus_if.we_n)
            rd_at = cyc;
         else
            wr_at = cyc;
      end
      if (read_data_start_q === 1'h1)
         rd_lat = cyc - rd_at;
      if (write_data_start_q === 1'h1)
         wr_lat = cyc - wr_at;
      if (auto_precharge_start_q === 1'h1)
         ap_lat = cyc - wr_at;
      if (dll_reset_q === 1'h1)
         pulses++;
   end
   initial begin
      sys_clk = 1'h0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      results();
   end
   initial begin
      nrst = 1'h0;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      void'($urandom(32'hbc30_9710));
      repeat (20) @(posedge sys_clk);
      nrst <= 1'h1;
      #1 chk("cl0", 0, column_latency_q);
      for (int i = 0; i < 24; i++) begin
         cl = 3 + $urandom % 4;
         wrc = 1 + $urandom % 5;
         pdx = $urandom % 2;
         al = $urandom % 5;
         termination_resistance = $urandom % 4;
         ex = $urandom & 13'h1C02;
         hot = $urandom % 2;
         load(BA_MR, 13'(pdx << 12 | wrc << 9 | cl << 4 | 2));
         load(BA_EMR, 13'(ex | (termination_resistance / 2) << 6 | (termination_resistance % 2) << 2 | al << 3));
         load(BA_SECOND_EXTENDED_REGISTER, 13'(hot << 7));
         chk("cl", cl, column_latency_q);
         chk("wr", wrc + 1, write_recovery_q);
         chk("fast", !pdx, fast_exit_q);
         chk("al", al, posted_extra_latency_q);
         chk("rl", al + cl, read_delay_total_q);
         chk("wl", al + cl - 1, write_delay_total_q);
         chk("drive", ex[1], drive_reduced_q);
         chk("oe", !ex[12], data_out_en_q);
         chk("dqsn", !ex[10] && !ex[12], strobe_complement_en_q);
         chk("redundant_strobe", ex[11] && !ex[12], redundant_strobe_en_q);
         chk("rdqsn", ex[11] && !ex[10] && !ex[12], redundant_complement_en_q);
         chk("rtt", rtt_ohm[termination_resistance], termination_resistance_q);
         chk("hot", hot, hot_refresh_rate_q);
         chk("dll", 1, dll_enabled_q);
         chk("clbad", 0, column_latency_bad_q);
         chk("third_extended_register", 0, |third_extended_register_q);
      end
      // latency code two, below the legal range, must not land
      load(BA_MR, 13'h0220);
      chk("clkeep", cl, column_latency_q);
      rd(REG_STATUS);
      chk("refused", 1, d[4]);
      wr(REG_STATUS, 32'h0000_0010);
      rd(8'hF0);
      chk("unmapped", 0, d[7:0]);
      load(BA_EMR, 13'h0004);
      load(BA_MR, 13'(wrc << 9 | cl << 4 | 2 | 13'h0100));
      load(BA_MR, 13'(wrc << 9 | cl << 4 | 2));
      chk("pulses", 1, pulses);
      acc(ACC_ACT);
      chk("bank", 1, bank_open_q);
      acc(ACC_READ);
      rd(REG_STATUS);
      chk("early", 1, d[4]);
      wr(REG_STATUS, 32'h0000_0010);
      repeat (200) @(posedge sys_clk);
      acc(ACC_READ);
      acc(ACC_WRAP);
      repeat (30) @(posedge sys_clk);
      chk("rlat", cl, rd_lat);
      chk("wlat", cl - 1, wr_lat);
      chk("aplat", cl - 1 + 2 + wrc + 1, ap_lat);
      wr(REG_CTRL, 32'h0000_0001);
      repeat (12) @(posedge sys_clk);
      chk("odt", 1, termination_on_q);
      acc(ACC_PRE);
      chk("bankoff", 0, bank_open_q);
      // reload with termination while the pin is wanted: pin must stay low
      load(BA_EMR, 13'h0040);
      chk("odthold", 0, termination_on_q);
      chk("rtt150", 8'h96, termination_resistance_q);
      repeat (8) @(posedge sys_clk);
      #1 chk("odtback", 1, termination_on_q);
      wr(REG_CTRL, 32'h0000_0003);
      repeat (20) @(posedge sys_clk);
      chk("sref", 1, self_refresh_q);
      chk("odtsr", 0, termination_on_q);
      chk("dllsr", 0, dll_enabled_q);
      wr(REG_CTRL, 32'h0000_0001);
      repeat (10) @(posedge sys_clk);
      chk("exit", 2, pulses);
      chk("pd", 0, power_down_q);
      chk("frozen", 0, dll_frozen_q);
      results();
   end
endmodule // tb_ddr2_mode_register_decode
